// ### src/eecc_defines.svh
// Register offsets, field positions, command codes and timing constants
`ifndef EECC_DEFINES_SVH
`define EECC_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define EECC_OFS_CLKDIV 12'h000
`define EECC_OFS_CNFG 12'h004
`define EECC_OFS_PROT 12'h008
`define EECC_OFS_STAT 12'h00c
`define EECC_OFS_CMD 12'h010
`define EECC_OFS_CTRL 12'h014
// Array window: bit 12 of the byte address selects the array
`define EECC_ARRAY_SEL_BIT 12
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define EECC_DIV_LD_BIT 7
`define EECC_DIV_PRE8_BIT 6
`define EECC_ST_BUFFERS_EMPTY_FLAG 7
`define EECC_ST_COMMAND_COMPLETE_FLAG 6
`define EECC_ST_PROTECTION_VIOLATION_FLAG 5
`define EECC_ST_ACCESS_ERROR_FLAG 4
`define EECC_ST_BLANK 2
`define EECC_ST_FAIL 1
`define EECC_ST_DONE 0
`define EECC_PR_OPEN 7
`define EECC_PR_DIS 3
`define EECC_PR_RST 8'h00
`define EECC_CTRL_STOP 0
`define EECC_CTRL_SPECIAL 1
// ----------------------------------------------------------------
// Commands
// ----------------------------------------------------------------
`define EECC_CMD_VERIFY 8'h05
`define EECC_CMD_PROG 8'h20
`define EECC_CMD_SERASE 8'h40
`define EECC_CMD_MERASE 8'h41
`define EECC_CMD_MODIFY 8'h60
// ----------------------------------------------------------------
// Timing: nvm_timing_clock ticks per operation
// ----------------------------------------------------------------
`define EECC_TICKS_PROG 16'h0008
`define EECC_TICKS_ERASE 16'h0010
`define EECC_TICKS_VERIFY 16'h0004
`define EECC_PRE8_DIV 4'h8

`endif

// ### src/eecc_pkg.sv
// Types shared by the command controller files
package eecc_pkg;
  typedef enum logic [3:0] {
    EECC_IDLE  = 4'b0001,
    EECC_ERASE = 4'b0010,
    EECC_PROG  = 4'b0100,
    EECC_VFY   = 4'b1000
  } eecc_exec_t;
  typedef enum logic [2:0] {
    EECC_SQ_EMPTY = 3'b001,
    EECC_SQ_WORD  = 3'b010,
    EECC_SQ_CMD   = 3'b100
  } eecc_seq_t;
endpackage

// ### src/eecc_tick_if.sv
// Divider configuration and timing tick between the controller and divider
`timescale 1ns/1ps
interface eecc_tick_if;
  logic pre8;
  logic [5:0] div;
  logic load;
  logic tick;
  modport ctl (output pre8, output div, output load, input tick);
  modport gen (input pre8, input div, input load, output tick);
endinterface

// ### src/eecc_timing_div.sv
// Divider producing the nvm_timing_clock enable pulse
`timescale 1ns/1ps
`include "eecc_defines.svh"
module eecc_timing_div (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Divider link
  eecc_tick_if.gen tk
);
  logic [3:0] pre_r;
  logic [6:0] cnt_r;
  logic pre_en;

  assign pre_en = !tk.pre8 || (pre_r == `EECC_PRE8_DIV - 4'h1);

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i || tk.load || pre_en)
      pre_r <= 4'h0;
    else
      pre_r <= pre_r + 4'h1;
  end

  // Divide by div+1 after the optional prescale
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i || tk.load)
    begin
      cnt_r <= 7'h00;
      tk.tick <= 1'b0;
    end
    else
    begin
      tk.tick <= 1'b0;
      if (pre_en)
      begin
        if (cnt_r >= {1'b0, tk.div})
        begin
          cnt_r <= 7'h00;
          tk.tick <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 7'h01;
      end
    end
  end
endmodule // eecc_timing_div

// ### src/eecc_ctrl.sv
// EEPROM command controller with AHB-Lite register and array port
// Function
// - Divider write sets divider loaded flag
// - No command runs before divider written
// - Word write latches address and data only
// - Address and data use depends on command
// - Writing one to buffers empty launches command
// - Complete flag sets after all queued commands
// - Writing zero to buffers empty aborts, errors
// - Verify, program and sector erase commands
// - Mass erase needs protection disable and open
// - Sector modify erases sector then programs word
// - Illegal array writes set access error
// - Illegal register writes set access error
// - Stop during operation aborts, sets access error
// - Reads never set access error
// - Either error flag locks command launch
// - Protected target sets protection violation
// - Two-stage command, address, data queue
// - Access error clears on write of one
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "eecc_defines.svh"
module eecc_ctrl #(
  parameter int AW = 10,
  parameter logic [AW-1:0] PROT_BASE = 10'h3f0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Array operation strobes
  output logic arr_erase_o,
  output logic arr_prog_o,
  output logic arr_mass_o,
  output logic [AW-1:0] arr_addr_o,
  output logic [15:0] arr_data_o
);
  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_r, rd_pend_r;
  logic [12:0] a_r;
  logic [2:0] sz_r;
  logic ap_valid;
  assign ap_valid = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      a_r <= 13'h0000;
      sz_r <= 3'h0;
    end
    else
    begin
      wr_pend_r <= ap_valid && hwrite_i;
      rd_pend_r <= ap_valid && !hwrite_i;
      if (ap_valid)
      begin
        a_r <= haddr_i[12:0];
        sz_r <= hsize_i;
      end
    end
  end

  logic is_arr;
  logic [11:0] ofs;
  assign is_arr = a_r[`EECC_ARRAY_SEL_BIT];
  assign ofs = a_r[11:0];

  // ----------------------------------------------------------------
  // Registers and divider
  // ----------------------------------------------------------------
  eecc_tick_if tk ();
  eecc_timing_div u_div (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .tk(tk)
  );

  logic div_ld_r, pre8_r, buffers_empty_flag_r, command_complete_flag_r, protection_violation_flag_r, access_error_flag_r, blank_r;
  logic fail_r, stop_r, special_r;
  logic [5:0] div_r;
  logic [7:0] cnfg_r, prot_r;
  eecc_pkg::eecc_seq_t seq_r;
  eecc_pkg::eecc_exec_t ex_r;
  // Front stage of the queue
  logic [7:0] b_cmd_r;
  logic [AW-1:0] b_addr_r;
  logic [15:0] b_data_r;
  logic b_full_r;
  // Active stage of the queue
  logic [7:0] x_cmd_r;
  logic [AW-1:0] x_addr_r;
  logic [15:0] x_data_r;
  logic x_busy_r;
  logic [15:0] tcnt_r;
  logic arr_dirty_r;

  assign tk.pre8 = pre8_r;
  assign tk.div = div_r;

  logic wr, wr_arr, wr_div, wr_stat, wr_cmd, wr_prot, wr_cnfg, wr_ctrl;
  assign wr = wr_pend_r;
  assign wr_arr = wr && is_arr;
  assign wr_div = wr && !is_arr && ofs == `EECC_OFS_CLKDIV;
  assign wr_cnfg = wr && !is_arr && ofs == `EECC_OFS_CNFG;
  assign wr_prot = wr && !is_arr && ofs == `EECC_OFS_PROT;
  assign wr_stat = wr && !is_arr && ofs == `EECC_OFS_STAT;
  assign wr_cmd = wr && !is_arr && ofs == `EECC_OFS_CMD;
  assign wr_ctrl = wr && !is_arr && ofs == `EECC_OFS_CTRL;
  assign tk.load = wr_div;

  logic cmd_ok, prot_hit, launch, abort0, err_acc, err_pv;
  logic [AW-1:0] waddr;
  logic [7:0] wcmd;
  assign waddr = a_r[AW:1] << 1;
  assign wcmd = hwdata_i[7:0];
  assign cmd_ok = wcmd == `EECC_CMD_VERIFY || wcmd == `EECC_CMD_PROG
    || wcmd == `EECC_CMD_SERASE || wcmd == `EECC_CMD_MERASE
    || wcmd == `EECC_CMD_MODIFY;
  assign prot_hit = !prot_r[`EECC_PR_OPEN]
    && (b_addr_r >= PROT_BASE) && wcmd != `EECC_CMD_VERIFY;
  logic mass_bad;
  assign mass_bad = wcmd == `EECC_CMD_MERASE
    && !(prot_r[`EECC_PR_DIS] && prot_r[`EECC_PR_OPEN]);
  assign launch = wr_stat && hwdata_i[`EECC_ST_BUFFERS_EMPTY_FLAG]
    && seq_r == eecc_pkg::EECC_SQ_CMD && !access_error_flag_r && !protection_violation_flag_r;
  assign abort0 = wr_stat && !hwdata_i[`EECC_ST_BUFFERS_EMPTY_FLAG]
    && seq_r != eecc_pkg::EECC_SQ_EMPTY;

  // Access error causes; reads never reach here
  always_comb
  begin
    err_acc = 1'b0;
    if (wr_arr)
      err_acc = !div_ld_r || sz_r != 3'h1 || a_r[0]
        || !buffers_empty_flag_r || seq_r != eecc_pkg::EECC_SQ_EMPTY;
    else if (wr && seq_r == eecc_pkg::EECC_SQ_WORD)
      err_acc = !wr_cmd || !(cmd_ok || special_r);
    else if (wr && seq_r == eecc_pkg::EECC_SQ_CMD)
      err_acc = !wr_stat || abort0;
    else if (abort0)
      err_acc = 1'b1;
    if (stop_r && x_busy_r)
      err_acc = 1'b1;
  end
  assign err_pv = wr_cmd && seq_r == eecc_pkg::EECC_SQ_WORD && !err_acc
    && (prot_hit || mass_bad);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      div_ld_r <= 1'b0;
      pre8_r <= 1'b0;
      div_r <= 6'h00;
    end
    else if (wr_div)
    begin
      div_ld_r <= 1'b1;
      pre8_r <= hwdata_i[`EECC_DIV_PRE8_BIT];
      div_r <= hwdata_i[5:0];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      cnfg_r <= 8'h00;
      prot_r <= `EECC_PR_RST;
      stop_r <= 1'b0;
      special_r <= 1'b0;
    end
    else
    begin
      if (wr_cnfg)
        cnfg_r <= hwdata_i[7:0];
      if (wr_prot)
        prot_r <= hwdata_i[7:0];
      if (wr_ctrl)
      begin
        stop_r <= hwdata_i[`EECC_CTRL_STOP];
        special_r <= hwdata_i[`EECC_CTRL_SPECIAL];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command write sequence and error flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      seq_r <= eecc_pkg::EECC_SQ_EMPTY;
      access_error_flag_r <= 1'b0;
      protection_violation_flag_r <= 1'b0;
      b_cmd_r <= 8'h00;
      b_addr_r <= '0;
      b_data_r <= 16'h0000;
    end
    else
    begin
      if (err_acc)
        access_error_flag_r <= 1'b1;
      else if (wr_stat && hwdata_i[`EECC_ST_ACCESS_ERROR_FLAG])
        access_error_flag_r <= 1'b0;
      if (err_pv)
        protection_violation_flag_r <= 1'b1;
      else if (wr_stat && hwdata_i[`EECC_ST_PROTECTION_VIOLATION_FLAG])
        protection_violation_flag_r <= 1'b0;
      if (err_acc || err_pv || launch)
        seq_r <= eecc_pkg::EECC_SQ_EMPTY;
      else if (wr_arr)
      begin
        seq_r <= eecc_pkg::EECC_SQ_WORD;
        b_addr_r <= waddr;
        b_data_r <= hwdata_i[15:0];
      end
      else if (wr_cmd && seq_r == eecc_pkg::EECC_SQ_WORD)
      begin
        seq_r <= eecc_pkg::EECC_SQ_CMD;
        b_cmd_r <= wcmd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-stage queue and execution
  // ----------------------------------------------------------------
  logic x_done;
  // A sector modify goes on to program after its erase phase
  assign x_done = x_busy_r && tk.tick && tcnt_r == 16'h0001
    && !(ex_r == eecc_pkg::EECC_ERASE && x_cmd_r == `EECC_CMD_MODIFY);
  logic ex_free;
  assign ex_free = !x_busy_r || x_done;

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i || (stop_r && x_busy_r))
      b_full_r <= 1'b0;
    else if (launch)
      b_full_r <= 1'b1;
    else if (b_full_r && ex_free)
      b_full_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      buffers_empty_flag_r <= 1'b1;
    else if (stop_r)
      buffers_empty_flag_r <= 1'b1;
    else if (launch)
      buffers_empty_flag_r <= ex_free;
    else if (b_full_r && ex_free)
      buffers_empty_flag_r <= 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      command_complete_flag_r <= 1'b1;
    else if (launch)
      command_complete_flag_r <= 1'b0;
    else if (stop_r && x_busy_r)
      command_complete_flag_r <= 1'b1;
    else if (x_done && !b_full_r)
      command_complete_flag_r <= 1'b1;
  end

  logic [15:0] load_ticks;
  logic [7:0] nxt_cmd;
  assign nxt_cmd = b_cmd_r;
  always_comb
  begin
    unique case (nxt_cmd)
      `EECC_CMD_PROG: load_ticks = `EECC_TICKS_PROG;
      `EECC_CMD_VERIFY: load_ticks = `EECC_TICKS_VERIFY;
      default: load_ticks = `EECC_TICKS_ERASE;
    endcase
  end

  logic start_b;
  assign start_b = b_full_r && ex_free;

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i || stop_r)
    begin
      ex_r <= eecc_pkg::EECC_IDLE;
      x_busy_r <= 1'b0;
      tcnt_r <= 16'h0000;
      x_cmd_r <= 8'h00;
      x_addr_r <= '0;
      x_data_r <= 16'h0000;
    end
    else if (start_b)
    begin
      x_busy_r <= 1'b1;
      x_cmd_r <= b_cmd_r;
      x_addr_r <= b_addr_r;
      x_data_r <= b_data_r;
      tcnt_r <= load_ticks;
      unique case (b_cmd_r)
        `EECC_CMD_VERIFY: ex_r <= eecc_pkg::EECC_VFY;
        `EECC_CMD_PROG: ex_r <= eecc_pkg::EECC_PROG;
        default: ex_r <= eecc_pkg::EECC_ERASE;
      endcase
    end
    else if (x_done)
    begin
      x_busy_r <= 1'b0;
      ex_r <= eecc_pkg::EECC_IDLE;
    end
    else if (x_busy_r && tk.tick)
    begin
      if (tcnt_r == 16'h0001)
      begin
        if (x_cmd_r == `EECC_CMD_MODIFY)
        begin
          ex_r <= eecc_pkg::EECC_PROG;
          tcnt_r <= `EECC_TICKS_PROG;
        end
        else
        begin
          ex_r <= eecc_pkg::EECC_IDLE;
          x_busy_r <= 1'b0;
        end
      end
      else
        tcnt_r <= tcnt_r - 16'h0001;
    end
  end

  // Array strobes and blank tracking
  logic ep;
  assign ep = x_busy_r && tk.tick && tcnt_r == 16'h0001;
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      arr_erase_o <= 1'b0;
      arr_prog_o <= 1'b0;
      arr_mass_o <= 1'b0;
      arr_addr_o <= '0;
      arr_data_o <= 16'h0000;
      arr_dirty_r <= 1'b1;
      blank_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else
    begin
      arr_erase_o <= ep && ex_r == eecc_pkg::EECC_ERASE
        && x_cmd_r != `EECC_CMD_MERASE;
      arr_mass_o <= ep && x_cmd_r == `EECC_CMD_MERASE;
      arr_prog_o <= ep && ex_r == eecc_pkg::EECC_PROG;
      arr_addr_o <= (ex_r == eecc_pkg::EECC_ERASE)
        ? (x_addr_r >> 2) << 2 : x_addr_r;
      arr_data_o <= x_data_r;
      if (ep && ex_r == eecc_pkg::EECC_PROG)
        arr_dirty_r <= 1'b1;
      else if (ep && x_cmd_r == `EECC_CMD_MERASE)
        arr_dirty_r <= 1'b0;
      if (launch)
        blank_r <= 1'b0;
      else if (ep && ex_r == eecc_pkg::EECC_VFY)
        blank_r <= !arr_dirty_r;
      if (ep && ex_r == eecc_pkg::EECC_VFY && arr_dirty_r)
        fail_r <= 1'b1;
      else if (wr_stat && hwdata_i[`EECC_ST_FAIL])
        fail_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      hrdata_o <= 32'h0000_0000;
    else if (ap_valid && !hwrite_i)
    begin
      hrdata_o <= 32'h0000_0000;
      if (!haddr_i[`EECC_ARRAY_SEL_BIT])
        unique case (haddr_i[11:0])
          `EECC_OFS_CLKDIV: hrdata_o <= {24'h0, div_ld_r, pre8_r, div_r};
          `EECC_OFS_CNFG: hrdata_o <= {24'h0, cnfg_r};
          `EECC_OFS_PROT: hrdata_o <= {24'h0, prot_r};
          `EECC_OFS_STAT: hrdata_o <= {24'h0, buffers_empty_flag_r, command_complete_flag_r, protection_violation_flag_r,
            access_error_flag_r, 1'b0, blank_r, fail_r, command_complete_flag_r};
          `EECC_OFS_CMD: hrdata_o <= {24'h0, b_cmd_r & 8'h65};
          `EECC_OFS_CTRL: hrdata_o <= {30'h0, special_r, stop_r};
          default: hrdata_o <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end
endmodule // eecc_ctrl

// ### verif/eecc_ctrl_props.sv
// Port checker for the EEPROM command controller
`timescale 1ns/1ps
module eecc_ctrl_props #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  // Array strobes
  input wire logic arr_erase_o,
  input wire logic arr_prog_o,
  input wire logic arr_mass_o,
  input wire logic [AW-1:0] arr_addr_o
);
  // ------------------------------------------------------------
  // Bus tracking
  // ------------------------------------------------------------
  logic ap;
  logic [12:0] a13;
  logic wdiv_q, rdiv_q, seen_q, seen2_q, wprot_q, open_q;
  assign ap = hsel_i && hready_i && htrans_i[1];
  assign a13 = haddr_i[12:0];
  always_ff @(posedge core_clk_i)
  begin
    wdiv_q <= rstn_i && ap && hwrite_i && a13 == 13'h0000;
    rdiv_q <= rstn_i && ap && !hwrite_i && a13 == 13'h0000;
    wprot_q <= rstn_i && ap && hwrite_i && a13 == 13'h0008;
    seen_q <= rstn_i && (seen_q || wdiv_q);
    seen2_q <= rstn_i && seen_q;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      open_q <= 1'b0;
    else if (wprot_q)
      open_q <= hwdata_i[7] && hwdata_i[3];
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_div_set: assert property (rdiv_q && seen2_q |-> hrdata_o[7])
    else $error("divider flag not set");
  a_div_clear: assert property (rdiv_q && !seen_q |-> !hrdata_o[7])
    else $error("divider flag set too early");
  a_no_early: assert property ((arr_prog_o || arr_erase_o) |-> seen_q)
    else $error("operation before divider load");
  a_sect_align: assert property (arr_erase_o && !arr_mass_o |->
    arr_addr_o[1:0] == 2'b00)
    else $error("sector erase address not aligned");
  a_prog_pulse: assert property (arr_prog_o |=> !arr_prog_o)
    else $error("program strobe longer than one cycle");
  a_erase_pulse: assert property ($rose(arr_erase_o) |=> $fell(arr_erase_o))
    else $error("erase strobe longer than one cycle");
  a_op_excl: assert property (!(arr_prog_o && arr_erase_o))
    else $error("erase and program together");
  a_mass_prot: assert property (arr_mass_o |-> open_q)
    else $error("mass erase while protected");
  c_prog: cover property (arr_prog_o);
  c_sect: cover property (arr_erase_o && !arr_mass_o);
  c_mass: cover property (arr_mass_o);
endmodule // eecc_ctrl_props

bind eecc_ctrl eecc_ctrl_props #(.AW(AW)) i_props (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .arr_erase_o(arr_erase_o), .arr_prog_o(arr_prog_o),
  .arr_mass_o(arr_mass_o), .arr_addr_o(arr_addr_o)
);

// ### verif/eecc_host_bfm.sv
// Bus master standing in for the processor core
`timescale 1ns/1ps
module eecc_host_bfm (
  // Clock
  input wire logic core_clk_i,
  // Bus master
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i
);
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0;
  end
  // Single transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [2:0] sz, input logic [31:0] d,
                      output logic [31:0] q);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o <= sz;
    @(posedge core_clk_i);
    while (hready_i !== 1'b1) @(posedge core_clk_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    haddr_o <= ~a;
    hwdata_o <= d;
    @(posedge core_clk_i);
    while (hready_i !== 1'b1) @(posedge core_clk_i);
    q = hrdata_i;
    hwdata_o <= ~d;
  endtask
  // Three-step command sequence
  task automatic seq(input logic [9:0] a, input logic [15:0] d,
                     input logic [7:0] c);
    logic [31:0] q;
    q = 32'h0;
    while (q[7] !== 1'b1) xfer(1'b0, 32'h00c, 3'b010, 32'h0, q);
    xfer(1'b1, {19'h0, 1'b1, 2'b00, a}, 3'b001, {d, d}, q);
    xfer(1'b1, 32'h010, 3'b010, {24'h0, c}, q);
    xfer(1'b1, 32'h00c, 3'b010, 32'h80, q);
  endtask
endmodule // eecc_host_bfm

// ### verif/test_eeprom_command_controller.sv
// Self-checking bench for the EEPROM command controller
`timescale 1ns/1ps
module test_eeprom_command_controller;
  logic core_clk_i;
  logic rstn_i;
  logic hsel, hwrite, hrdy, hresp, er, pr, ms;
  logic [31:0] haddr, hwdata, hrdata, lf, q, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] aa;
  logic [15:0] ad;
  logic [28:0] ops[$];
  int error_cnt, num_checks;
  eecc_ctrl #(.AW(10)) i_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .arr_erase_o(er), .arr_prog_o(pr), .arr_mass_o(ms),
    .arr_addr_o(aa), .arr_data_o(ad)
  );
  eecc_host_bfm i_host (
    .core_clk_i(core_clk_i), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata), .hready_i(hrdy), .hrdata_i(hrdata)
  );
  initial core_clk_i = 1'b0;
  always #12.5 core_clk_i = ~core_clk_i;
  // Log of every array strobe
  always @(posedge core_clk_i)
    if (er || pr || ms)
      ops.push_back({ms, pr, er, aa, ad});
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, 3'b010, d, r);
  endtask
  task automatic rd(input logic [31:0] a);
    i_host.xfer(1'b0, a, 3'b010, 32'h0, q);
  endtask
  task automatic aw(input logic [9:0] a, input logic [15:0] d);
    i_host.xfer(1'b1, {19'h0, 1'b1, 2'b00, a}, 3'b001, {d, d}, r);
  endtask
  task automatic clr();
    wr(32'h00c, 32'hb0);
  endtask
  task automatic chk_err(input logic [1:0] e);
    rd(32'h00c);
    check("err", 32'(q[5:4]), 32'(e));
    check("resp", 32'({hresp, hrdy}), 32'h1);
  endtask
  task automatic idle();
    q = 32'h0;
    while (q[6] !== 1'b1) rd(32'h00c);
  endtask
  task automatic expect_op(input logic [2:0] k, input logic [9:0] a,
                           input logic [15:0] d);
    logic [28:0] e;
    int n;
    n = 0;
    while (ops.size() == 0 && n < 40000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    e = ops.size() > 0 ? ops.pop_front() : 29'h0;
    if (k[2])
      check("mass", 32'(e[28]), 32'h1);
    else
      check("op", 32'(e), 32'({k, a, k[1] ? d : e[15:0]}));
  endtask
  initial
  begin
    #2000000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    rstn_i = 1'b0;
    lf = 32'h075f;
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(32'h000);
    check("div", 32'(q[7]), 32'h0);
    rd(32'h00c);
    check("rst", 32'(q[7:4]), 32'hc);
    aw(10'h010, 16'h1234);
    chk_err(2'b01);
    wr(32'h00c, 32'h20);
    chk_err(2'b01);
    clr();
    chk_err(2'b00);
    wr(32'h000, 32'h5b);
    rd(32'h000);
    check("div", 32'(q[7:0]), 32'hdb);
    wr(32'h008, 32'h00);
    i_host.seq(10'h000, 16'h0, 8'h41);
    chk_err(2'b10);
    clr();
    wr(32'h008, 32'h88);
    i_host.seq(10'h000, 16'h0, 8'h41);
    expect_op(3'b100, 10'h0, 16'h0);
    i_host.seq(10'h000, 16'h0, 8'h05);
    idle();
    rd(32'h00c);
    check("blank", 32'(q[2]), 32'h1);
    wr(32'h008, 32'h00);
    for (int i = 0; i < 3; i++)
    begin
      lf = nxt(lf);
      i_host.seq(10'h100 + 10'(4 * i), lf[15:0], 8'h20);
      rd(32'h00c);
      check("busy", 32'(q[6]), 32'h0);
      expect_op(3'b010, 10'h100 + 10'(4 * i), lf[15:0]);
      idle();
      chk_err(2'b00);
    end
    i_host.seq(10'h00e, 16'hffff, 8'h40);
    expect_op(3'b001, 10'h00c, 16'h0);
    lf = nxt(lf);
    i_host.seq(10'h206, lf[15:0], 8'h60);
    i_host.seq(10'h204, lf[31:16], 8'h20);
    expect_op(3'b001, 10'h204, 16'h0);
    expect_op(3'b010, 10'h206, lf[15:0]);
    rd(32'h00c);
    check("cc", 32'(q[6]), 32'h0);
    expect_op(3'b010, 10'h204, lf[31:16]);
    idle();
    i_host.seq(10'h3f4, lf[15:0], 8'h20);
    chk_err(2'b10);
    i_host.seq(10'h110, lf[15:0], 8'h20);
    repeat (2500) @(posedge core_clk_i);
    check("lock", 32'(ops.size()), 32'h0);
    // Drop the refused sequence so the next test starts clean
    wr(32'h00c, 32'h20);
    chk_err(2'b01);
    clr();
    i_host.seq(10'h120, 16'h0, 8'h33);
    chk_err(2'b01);
    clr();
    aw(10'h120, 16'h0);
    wr(32'h00c, 32'h00);
    chk_err(2'b01);
    clr();
    aw(10'h120, 16'h0);
    aw(10'h124, 16'h0);
    chk_err(2'b01);
    clr();
    i_host.seq(10'h300, 16'h0, 8'h40);
    repeat (20) @(posedge core_clk_i);
    wr(32'h014, 32'h1);
    // Error flag follows the stop bit by one cycle
    @(posedge core_clk_i);
    chk_err(2'b01);
    wr(32'h014, 32'h0);
    clr();
    repeat (4000) @(posedge core_clk_i);
    check("none", 32'(ops.size()), 32'h0);
    final_report();
  end
endmodule // test_eeprom_command_controller
